// file: lvlps_link_model.sv
// Cable model that carries the transmit lanes back to the receive lanes.
`timescale 1ns/1ps
module lvlps_link_model (
    // Clock
    input wire logic clk,
    // Transmit end
    input wire lvlps_pkg::lvlps_serial_t tx_wire,
    input wire logic tx_oe,
    // Receive end
    output lvlps_pkg::lvlps_serial_t rx_wire = '1
);
    // ==========================================================
    // Cable
    // Undriven pairs read high because of the receiver failsafe bias.
    always @(posedge clk) begin
        if (tx_oe) begin
            rx_wire <= tx_wire;
        end else begin
            rx_wire <= '1;
        end
    end
endmodule : lvlps_link_model

// file: lvlps_pkg.sv
// Shared constants and carrier types for the LVDS link power sequencer.
package lvlps_pkg;

    // ==========================================================
    // Link geometry
    localparam int LANES = 4;
    localparam int BITS_PER_LANE = 7;
    localparam int WORD_W = 28;
    localparam int CLK_HIGH_BITS = 4;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int STARTUP_DELAY_MS = 10;
    localparam int STARTUP_CYCLES = STARTUP_DELAY_MS * 1000 * CLK_MHZ;
    localparam int STARTUP_CNT_W = 21;
    localparam int PERIOD_CNT_W = 16;

    // ==========================================================
    // Reset values
    localparam logic [2:0] BIT_IDX_RST = 3'h0;
    localparam logic [3:0] LANES_RST = 4'h0;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [LANES-1:0] lanes;
        logic clk;
    } lvlps_serial_t;

    typedef enum logic [1:0] {
        LVLPS_OFF = 2'h0,
        LVLPS_WAIT = 2'h1,
        LVLPS_RUN = 2'h3
    } lvlps_state_t;

endpackage : lvlps_pkg

// file: lvlps_sync.sv
// Two-flop synchroniser for pins arriving from outside the clock domain.
`timescale 1ns/1ps
module lvlps_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : lvlps_sync

// file: lvlps_top.sv
// Power-down sequencing, 7:1 serializer and deserializer of the LVDS link.
`timescale 1ns/1ps
module lvlps_top #(
    parameter int STARTUP_CYCLES = lvlps_pkg::STARTUP_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Power control pins
    input wire logic supply_good,
    input wire logic low_power_request_n,
    // Parallel source side
    input wire logic parallel_strobe_clock_in,
    input wire logic [lvlps_pkg::WORD_W-1:0] parallel_data_in,
    // Serial transmit link
    output lvlps_pkg::lvlps_serial_t serial_data_lanes,
    output logic serial_data_lanes_oe,
    // Serial receive link
    input wire lvlps_pkg::lvlps_serial_t serial_rx,
    // Recovered parallel side
    output logic [lvlps_pkg::WORD_W-1:0] recovered_parallel_data,
    output logic recovered_strobe_clock
);
    localparam int L = lvlps_pkg::LANES;
    localparam int B = lvlps_pkg::BITS_PER_LANE;
    localparam int PW = lvlps_pkg::PERIOD_CNT_W;
    localparam int SW = lvlps_pkg::STARTUP_CNT_W;
    localparam logic [2:0] LAST_BIT = 3'(B - 1);
    localparam logic [2:0] HIGH_BITS = 3'(lvlps_pkg::CLK_HIGH_BITS);
    localparam logic [SW-1:0] START_LAST = SW'(STARTUP_CYCLES - 1);
    localparam logic [2:0] BIT_IDX_RST_C = lvlps_pkg::BIT_IDX_RST;

    if (L * B != lvlps_pkg::WORD_W || STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << SW))
    begin : g_bad_params
        $error("Unsupported link geometry or start-up count.");
    end

    function automatic logic [L-1:0] pick(input logic [L*B-1:0] w, input logic [2:0] idx);
        logic [L-1:0] r;
        r = '0;
        for (int l = 0; l < L; l++) begin
            r[l] = w[l*B + int'(idx)];
        end
        return r;
    endfunction : pick

    // ==========================================================
    // Pin synchronisers
    logic supply_s, pd_n_s, stb_s, rx_clk_s;
    logic [L*B-1:0] data_s;
    logic [L-1:0] rx_lanes_s;
    lvlps_pkg::lvlps_serial_t rx_s;

    lvlps_sync #(.W(2)) u_sync_ctl (
        .clk(clk), .resetn(resetn),
        .d({supply_good, low_power_request_n}), .q({supply_s, pd_n_s})
    );
    lvlps_sync #(.W(L*B+1)) u_sync_tx (
        .clk(clk), .resetn(resetn),
        .d({parallel_strobe_clock_in, parallel_data_in}), .q({stb_s, data_s})
    );
    lvlps_sync #(.W(L+1)) u_sync_rx (
        .clk(clk), .resetn(resetn),
        .d(serial_rx), .q(rx_s)
    );
    assign rx_clk_s = rx_s.clk;
    assign rx_lanes_s = rx_s.lanes;

    // ==========================================================
    // Power sequencing
    lvlps_pkg::lvlps_state_t state_q;
    logic [SW-1:0] start_cnt_q;
    logic power_ok;
    logic run;

    assign power_ok = pd_n_s && supply_s;
    assign run = (state_q == lvlps_pkg::LVLPS_RUN) && power_ok;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= lvlps_pkg::LVLPS_OFF;
        end else if (!power_ok) begin
            state_q <= lvlps_pkg::LVLPS_OFF;
        end else begin
            case (state_q)
                lvlps_pkg::LVLPS_OFF: state_q <= lvlps_pkg::LVLPS_WAIT;
                lvlps_pkg::LVLPS_WAIT: begin
                    if (start_cnt_q == START_LAST) begin
                        state_q <= lvlps_pkg::LVLPS_RUN;
                    end
                end
                lvlps_pkg::LVLPS_RUN: state_q <= lvlps_pkg::LVLPS_RUN;
                default: state_q <= lvlps_pkg::LVLPS_OFF;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !power_ok || state_q != lvlps_pkg::LVLPS_WAIT) begin
            start_cnt_q <= '0;
        end else if (start_cnt_q != START_LAST) begin
            start_cnt_q <= start_cnt_q + SW'(1);
        end
    end

    // ==========================================================
    // Transmit serializer
    logic stb_d_q, stb_rise;
    logic [PW-1:0] tx_per_q, tx_len_q, tx_bcnt_q;
    logic [2:0] tx_idx_q;
    logic [L*B-1:0] tx_frame_q;

    assign stb_rise = stb_s && !stb_d_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            stb_d_q <= 1'b0;
            tx_per_q <= '0;
            tx_len_q <= PW'(1);
        end else begin
            stb_d_q <= stb_s;
            if (stb_rise) begin
                tx_per_q <= PW'(1);
                tx_len_q <= (tx_per_q < PW'(B)) ? PW'(1) : PW'(tx_per_q / PW'(B));
            end else if (tx_per_q != '1) begin
                tx_per_q <= tx_per_q + PW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_frame_q <= '0;
            tx_idx_q <= BIT_IDX_RST_C;
            tx_bcnt_q <= '0;
        end else if (stb_rise) begin
            tx_frame_q <= data_s;
            tx_idx_q <= BIT_IDX_RST_C;
            // Bit 0 goes out in the edge cycle itself, so that cycle already counts.
            tx_bcnt_q <= PW'(1);
        end else if (tx_bcnt_q + PW'(1) >= tx_len_q) begin
            tx_bcnt_q <= '0;
            if (tx_idx_q != LAST_BIT) begin
                tx_idx_q <= tx_idx_q + 3'h1;
            end
        end else begin
            tx_bcnt_q <= tx_bcnt_q + PW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !run) begin
            serial_data_lanes.lanes <= lvlps_pkg::LANES_RST;
            serial_data_lanes.clk <= 1'b0;
            serial_data_lanes_oe <= 1'b0;
        end else begin
            serial_data_lanes_oe <= 1'b1;
            if (stb_rise) begin
                serial_data_lanes.lanes <= pick(data_s, BIT_IDX_RST_C);
                serial_data_lanes.clk <= 1'b1;
            end else begin
                serial_data_lanes.lanes <= pick(tx_frame_q, tx_idx_q);
                serial_data_lanes.clk <= (tx_idx_q < HIGH_BITS);
            end
        end
    end

    // ==========================================================
    // Receive deserializer
    logic rx_clk_d_q, rx_rise;
    logic [PW-1:0] rx_per_q, rx_len_q, rx_bcnt_q;
    logic [2:0] rx_idx_q;
    logic [3:0] rx_got_q;
    logic [L*B-1:0] rx_frame_q;
    logic rx_present;

    assign rx_rise = rx_clk_s && !rx_clk_d_q;
    assign rx_present = rx_rise && (rx_got_q == 4'(B));

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_clk_d_q <= 1'b0;
            rx_per_q <= '0;
            rx_len_q <= PW'(1);
        end else begin
            rx_clk_d_q <= rx_clk_s;
            if (rx_rise) begin
                rx_per_q <= PW'(1);
                rx_len_q <= (rx_per_q < PW'(B)) ? PW'(1) : PW'(rx_per_q / PW'(B));
            end else if (rx_per_q != '1) begin
                rx_per_q <= rx_per_q + PW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_idx_q <= BIT_IDX_RST_C;
            rx_bcnt_q <= '0;
            rx_got_q <= 4'h0;
            rx_frame_q <= '0;
        end else if (rx_rise) begin
            rx_idx_q <= BIT_IDX_RST_C;
            rx_bcnt_q <= '0;
            rx_got_q <= 4'h0;
        end else begin
            // The slot began one cycle before the count restarted, so mid-slot sits one earlier.
            if (rx_bcnt_q == ((rx_len_q - PW'(1)) >> 1) && rx_got_q == {1'b0, rx_idx_q}) begin
                for (int l = 0; l < L; l++) begin
                    rx_frame_q[l*B + int'(rx_idx_q)] <= rx_lanes_s[l];
                end
                rx_got_q <= rx_got_q + 4'h1;
            end
            if (rx_bcnt_q + PW'(1) >= rx_len_q) begin
                rx_bcnt_q <= '0;
                if (rx_idx_q != LAST_BIT) begin
                    rx_idx_q <= rx_idx_q + 3'h1;
                end
            end else begin
                rx_bcnt_q <= rx_bcnt_q + PW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !pd_n_s) begin
            recovered_parallel_data <= '0;
            recovered_strobe_clock <= 1'b0;
        end else if (rx_present) begin
            recovered_parallel_data <= rx_frame_q;
            recovered_strobe_clock <= 1'b1;
        end else if (!rx_rise && rx_idx_q >= HIGH_BITS) begin
            recovered_strobe_clock <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    chk_lane_first_bit: assert property (@(posedge clk) disable iff (!resetn)
        (run && stb_rise && $past(run)) |=> (serial_data_lanes.lanes == pick($past(data_s), 3'h0)))
        else $error("Lane bit 0 does not match sampled word.");
    chk_bit_index_bound: assert property (@(posedge clk) disable iff (!resetn)
        stb_rise |=> (tx_idx_q == 3'h0) ##1 (tx_idx_q <= 3'h1))
        else $error("Bit index outside one frame.");
    chk_quiet_until_run: assert property (@(posedge clk) disable iff (!resetn)
        (state_q != lvlps_pkg::LVLPS_RUN) |=> !serial_data_lanes_oe)
        else $error("Outputs driven before start-up delay expired.");
    chk_startup_expiry: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == lvlps_pkg::LVLPS_WAIT && power_ok && start_cnt_q == START_LAST)
        |=> (state_q == lvlps_pkg::LVLPS_RUN) ##1 (serial_data_lanes_oe == $past(power_ok)))
        else $error("Start-up delay did not end on its count.");
    chk_pd_restarts_cnt: assert property (@(posedge clk) disable iff (!resetn)
        !pd_n_s |=> (start_cnt_q == '0) && (state_q == lvlps_pkg::LVLPS_OFF))
        else $error("Power-down did not restart the start-up counter.");
    chk_tx_undriven: assert property (@(posedge clk) disable iff (!resetn)
        !pd_n_s |=> !serial_data_lanes_oe && (serial_data_lanes == '0))
        else $error("Transmitter driven during power-down.");
    chk_rx_forced_low: assert property (@(posedge clk) disable iff (!resetn)
        !pd_n_s |=> (recovered_parallel_data == '0) && !recovered_strobe_clock)
        else $error("Receiver outputs not low during power-down.");
    chk_rx_hold_value: assert property (@(posedge clk) disable iff (!resetn)
        (pd_n_s && !rx_present) |=> $stable(recovered_parallel_data))
        else $error("Receiver data changed without a link clock edge.");
    chk_rx_present_edge: assert property (@(posedge clk) disable iff (!resetn)
        (pd_n_s && rx_present) |=> recovered_strobe_clock
        && (recovered_parallel_data == $past(rx_frame_q)))
        else $error("Recovered word not presented with clock rise.");
endmodule : lvlps_top

// file: tb.sv
// Self-checking bench for power sequencing, serial transfer and power-down of the link block.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected at %0t: %s", $time, msg); end end
module tb;
    localparam int N = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic supply_good = 1'b1;
    logic low_power_request_n = 1'b0;
    logic strobe = 1'b0;
    logic strobe_run = 1'b1;
    logic note_on = 1'b0;
    logic note_arm = 1'b0;
    logic [3:0] phase = 4'h0;
    logic [31:0] rnd = 32'h22;
    logic [lvlps_pkg::WORD_W-1:0] word = '0;
    logic [lvlps_pkg::WORD_W-1:0] last;
    logic [lvlps_pkg::WORD_W-1:0] rx_word;
    logic [lvlps_pkg::WORD_W-1:0] notes[$];
    lvlps_pkg::lvlps_serial_t tx_wire;
    lvlps_pkg::lvlps_serial_t rx_wire;
    logic tx_oe;
    logic rx_clk;
    logic rx_clk_prev = 1'b0;
    int miscompares = 0;
    int check_count = 0;
    int n;

    lvlps_top #(.STARTUP_CYCLES(N)) i_dut (
        .clk(clk), .resetn(resetn), .supply_good(supply_good),
        .low_power_request_n(low_power_request_n), .parallel_strobe_clock_in(strobe),
        .parallel_data_in(word), .serial_data_lanes(tx_wire), .serial_data_lanes_oe(tx_oe),
        .serial_rx(rx_wire), .recovered_parallel_data(rx_word), .recovered_strobe_clock(rx_clk)
    );
    lvlps_link_model i_link (.clk(clk), .tx_wire(tx_wire), .tx_oe(tx_oe), .rx_wire(rx_wire));

    initial begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // ==========================================================
    // Parallel source: 14-cycle strobe, data changes mid-low and is noted at each rise.
    always @(posedge clk) begin
        if (strobe_run) begin
            phase <= (phase == 4'hD) ? 4'h0 : phase + 4'h1;
            strobe <= (phase < 4'h7);
            // Notes start only once a fresh word has been set up, so no frame is skipped.
            if (phase == 4'h0 && note_arm) notes.push_back(word);
            if (phase == 4'h9 && note_on) rnd <= lfsr(rnd);
            if (phase == 4'hA) note_arm <= note_on;
            if (phase == 4'hA && note_on) word <= rnd[27:0];
        end else begin
            phase <= 4'h0;
            strobe <= 1'b0;
        end
    end

    // ==========================================================
    // Output watcher: each recovered clock rise with a non-zero word takes the oldest note.
    always @(posedge clk) begin
        rx_clk_prev <= rx_clk;
        if (rx_clk && !rx_clk_prev && notes.size() > 0 && rx_word !== '0) begin
            `CHK(rx_word, notes.pop_front(), "recovered word")
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic ran_out(input string what);
        miscompares++;
        $display("unexpected at %0t: %s wait ran out", $time, what);
        final_report();
    endtask : ran_out

    task automatic wait_oe(input logic lvl, output int cnt);
        cnt = 0;
        while (tx_oe !== lvl && cnt < 200) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (cnt >= 200) begin
            ran_out("output enable");
        end
    endtask : wait_oe

    task automatic check_frame();
        logic [lvlps_pkg::WORD_W-1:0] w;
        logic [lvlps_pkg::LANES-1:0] exp_l;
        n = 0;
        while (phase != 4'h0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) begin
            ran_out("strobe phase");
        end
        w = word;
        repeat (4) @(posedge clk);
        for (int b = 0; b < lvlps_pkg::BITS_PER_LANE; b++) begin
            @(negedge clk);
            for (int l = 0; l < lvlps_pkg::LANES; l++) exp_l[l] = w[l * 7 + b];
            `CHK(tx_wire.lanes, exp_l, "lane bit")
            `CHK(tx_wire.clk, (b < lvlps_pkg::CLK_HIGH_BITS), "link clock")
            repeat (2) @(posedge clk);
        end
    endtask : check_frame

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        low_power_request_n <= 1'b1;
        repeat (10) @(posedge clk);
        low_power_request_n <= 1'b0;
        repeat (5) @(posedge clk);
        `CHK(tx_oe, 1'b0, "enabled during start-up")
        low_power_request_n <= 1'b1;
        wait_oe(1'b1, n);
        // One cycle of slack either way around the sequencer walk.
        `CHK(n >= N + 3 && n <= N + 5, 1'b1, "start-up delay")
        $display("test startup done");
        @(posedge clk);
        note_on <= 1'b1;
        repeat (3) check_frame();
        repeat (6 * 14) @(posedge clk);
        note_on <= 1'b0;
        n = 0;
        while (notes.size() > 0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) begin
            ran_out("recovery");
        end
        `CHK(notes.size(), 0, "words not recovered")
        last = word;
        $display("test transfer done");
        @(posedge clk);
        supply_good <= 1'b0;
        repeat (40) @(posedge clk);
        #1;
        `CHK(tx_oe, 1'b0, "driving without power")
        `CHK(rx_word, last, "held data lost")
        $display("test link loss done");
        @(posedge clk);
        supply_good <= 1'b1;
        wait_oe(1'b1, n);
        repeat (20) @(posedge clk);
        low_power_request_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK(tx_oe, 1'b0, "enable after power-down")
        `CHK(tx_wire, '0, "lanes after power-down")
        `CHK(rx_word, '0, "receiver data after power-down")
        @(posedge clk);
        strobe_run <= 1'b0;
        repeat (30) @(posedge clk);
        strobe_run <= 1'b1;
        repeat (30) @(posedge clk);
        low_power_request_n <= 1'b1;
        wait_oe(1'b1, n);
        `CHK(n >= N + 3 && n <= N + 5, 1'b1, "restart delay")
        $display("test power-down done");
        final_report();
    end
endmodule : tb
